/* logic/timer_one_regs.svh */
// Register offsets, field positions, reset values and timing counts of the 16-bit timer.
`ifndef TIMER_ONE_REGS_SVH
`define TIMER_ONE_REGS_SVH
// -----------------------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_COUNT_LOW 8'h04
`define OFS_COUNT_HIGH 8'h08
`define OFS_IRQ_STATUS 8'h0c
`define OFS_IRQ_MASK 8'h10
// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define CTRL_WIDTH 6
`define OVF_BIT 0
`define CTRL_RESET 6'h00
`define COUNT_RESET 16'h0000
`define COUNT_ALL_ONES 16'hffff
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define CLOCK_PERIOD_NS 25
`define INSTR_CLOCK_DIV 4
`endif

/* logic/timer_one_pkg.sv */
// Types shared by the 16-bit timer.
package timer_one_pkg;
  // Control register layout, bit 0 upward: enable, source, sync disable, crystal, prescale.
  typedef struct packed {
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic external_sync_disable;
    logic clock_source_select;
    logic count_enable;
  } ctrl_type;

  typedef enum logic {WAIT_FALL, ARMED} arm_type;
endpackage : timer_one_pkg

/* logic/timer_one.sv */
// Sixteen-bit timer/counter with prescaler, overflow interrupt and AHB-Lite registers.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "timer_one_regs.svh"

// Overview of operation
// - Count is two byte halves, low and high, both read and write.
// - Count goes up through all 16 bits and wraps from all ones to zero.
// - Every wrap sets a sticky overflow flag in status bit 0.
// - Interrupt is raised only when the overflow enable bit 0 is set.
// - Control bit 1 picks external pin rising edges or instruction clock.
// - Internal source advances once per instruction cycle after the prescaler.
// - External source advances on pin rising edges after the prescaler.
// - Counting only while control bit 0 is set; clearing it holds the value.
// - Either capture/compare reset input clears the count.
// - Control bits 5:4 pick prescale 1, 2, 4 or 8.
// - Control bits 7:6 ignore writes and read zero.
// - Control bit 3 powers the crystal oscillator inverter, off when clear.
// - In external mode bit 2 clear synchronises, set leaves it unsynchronised.
// - Crystal enabled forces both pins to inputs reading zero.
// - Internal source ignores the synchronisation bit.
// - External mode needs one falling edge after enable before counting.
// - Synchronisation follows the prescaler, which acts as a ripple counter.
module timer_one
  import timer_one_pkg::*;
#(
  parameter int INSTR_DIV = `INSTR_CLOCK_DIV
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] CCP_RESET,
  input wire logic [1:0] PIN_IN,
  input wire logic [1:0] PORT_DIR,
  input wire logic [1:0] PORT_OUT,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE,
  output logic [1:0] PIN_READ,
  output logic OSC_INV_EN,
  output logic IRQ
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  ctrl_type ctrl_r;
  logic [15:0] count_r;
  logic flag_r;
  logic mask_r;
  logic irq_r;
  logic [31:0] hrdata_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic ext_prev_r;
  arm_type arm_r;
  logic [1:0] div_r;
  logic [2:0] psc_r;
  logic sync_tick_r;
  logic [1:0] pin_oe_r;
  logic [1:0] pin_out_r;
  logic [1:0] pin_read_r;
  logic osc_inv_r;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire ahb_take = HSEL && HREADY && HTRANS[1];
  wire [7:0] rd_addr = HADDR[7:0];
  wire rd_hit_status = ahb_take && !HWRITE && (rd_addr == `OFS_IRQ_STATUS);
  wire wr_ctrl = wr_pend_r && (wr_addr_r == `OFS_CONTROL);
  wire wr_low = wr_pend_r && (wr_addr_r == `OFS_COUNT_LOW);
  wire wr_high = wr_pend_r && (wr_addr_r == `OFS_COUNT_HIGH);
  wire wr_mask = wr_pend_r && (wr_addr_r == `OFS_IRQ_MASK);
  wire [31:0] rd_data =
    (rd_addr == `OFS_CONTROL) ? {26'h0, ctrl_r} :
    (rd_addr == `OFS_COUNT_LOW) ? {24'h0, count_r[7:0]} :
    (rd_addr == `OFS_COUNT_HIGH) ? {24'h0, count_r[15:8]} :
    (rd_addr == `OFS_IRQ_STATUS) ? {31'h0, flag_r} :
    (rd_addr == `OFS_IRQ_MASK) ? {31'h0, mask_r} : 32'h0;
  // Only the low six bits of a control write are kept; bits 7:6 read zero.
  wire ctrl_type ctrl_nxt = wr_ctrl ? ctrl_type'(HWDATA[`CTRL_WIDTH-1:0]) : ctrl_r;

  // ---------------------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------------------
  // Pin 0 carries the external count input, pin 1 the crystal input.
  wire ext_lvl = ctrl_r.crystal_osc_enable ? pin_s2_r[1] : pin_s2_r[0];
  wire ext_rise = ext_lvl && !ext_prev_r;
  wire ext_fall = !ext_lvl && ext_prev_r;
  wire ext_mode = ctrl_r.count_enable && ctrl_r.clock_source_select;
  wire instr_tick = (div_r == 2'(INSTR_DIV - 1));
  wire src_tick = ctrl_r.clock_source_select ? (ext_rise && arm_r == ARMED) : instr_tick;
  wire [2:0] psc_mask = 3'((4'h1 << ctrl_r.prescale_select) - 4'h1);
  wire psc_hit = ctrl_r.count_enable && src_tick && ((psc_r & psc_mask) == psc_mask);
  wire use_sync = ctrl_r.clock_source_select && !ctrl_r.external_sync_disable;
  wire inc = ctrl_r.count_enable && (use_sync ? sync_tick_r : psc_hit);
  wire ccp_clear = |CCP_RESET;
  wire wrap = inc && !ccp_clear && !wr_low && !wr_high && (count_r == `COUNT_ALL_ONES);
  wire flag_nxt = wrap || (flag_r && !rd_hit_status);
  wire mask_nxt = wr_mask ? HWDATA[`OVF_BIT] : mask_r;

  // ---------------------------------------------------------------------------
  // Bus registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      ctrl_r <= `CTRL_RESET;
      mask_r <= 1'b0;
      hrdata_r <= 32'h0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      hrdata_r <= (ahb_take && !HWRITE) ? rd_data : 32'h0;
      wr_pend_r <= ahb_take && HWRITE;
      wr_addr_r <= HADDR[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Synchronisers, divider, arming, prescaler
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      ext_prev_r <= 1'b0;
      div_r <= 2'h0;
    end
    else
    begin
      pin_s1_r <= PIN_IN;
      pin_s2_r <= pin_s1_r;
      ext_prev_r <= ext_lvl;
      div_r <= instr_tick ? 2'h0 : div_r + 2'h1;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || !ext_mode)
      arm_r <= WAIT_FALL;
    else if (arm_r == WAIT_FALL && ext_fall)
      arm_r <= ARMED;
  end

  // The prescaler behaves as a ripple chain: it only advances on source ticks.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || ccp_clear || wr_low || wr_high)
    begin
      psc_r <= 3'h0;
      sync_tick_r <= 1'b0;
    end
    else
    begin
      if (ctrl_r.count_enable && src_tick)
        psc_r <= psc_r + 3'h1;
      sync_tick_r <= psc_hit && use_sync;
    end
  end

  // ---------------------------------------------------------------------------
  // Count, flag and interrupt
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      count_r <= `COUNT_RESET;
    else if (ccp_clear)
      count_r <= `COUNT_RESET;
    else if (wr_low)
      count_r <= {count_r[15:8], HWDATA[7:0]};
    else if (wr_high)
      count_r <= {HWDATA[7:0], count_r[7:0]};
    else if (inc)
      count_r <= count_r + 16'h0001;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      flag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      irq_r <= flag_nxt && mask_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      pin_oe_r <= 2'h0;
      pin_out_r <= 2'h0;
      pin_read_r <= 2'h0;
      osc_inv_r <= 1'b0;
    end
    else
    begin
      pin_oe_r <= ctrl_nxt.crystal_osc_enable ? 2'h0 : ~PORT_DIR;
      pin_out_r <= PORT_OUT;
      pin_read_r <= ctrl_nxt.crystal_osc_enable ? 2'h0 : pin_s2_r;
      osc_inv_r <= ctrl_nxt.crystal_osc_enable;
    end
  end

  assign HRDATA = hrdata_r;
  assign HREADYOUT = !SYS_RST || 1'b1;
  assign HRESP = 1'b0;
  assign PIN_OUT = pin_out_r;
  assign PIN_OE = pin_oe_r;
  assign PIN_READ = pin_read_r;
  assign OSC_INV_EN = osc_inv_r;
  assign IRQ = irq_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_count_holds_off: assert property (
    !ctrl_r.count_enable && !ccp_clear && !wr_low && !wr_high |=> $stable(count_r))
    else $error("count moved while stopped");
  a_count_wraps_zero: assert property (
    wrap |=> count_r == 16'h0000 && flag_r)
    else $error("wrap did not reach zero with flag");
  a_flag_sticky: assert property (
    flag_r && !rd_hit_status |=> flag_r)
    else $error("overflow flag lost");
  a_irq_gated: assert property (
    ##1 IRQ == (flag_r && mask_r))
    else $error("interrupt does not follow flag and mask");
  a_ccp_clears: assert property (
    ccp_clear |=> count_r == 16'h0000)
    else $error("capture/compare reset did not clear count");
  a_ctrl_high_zero: assert property (
    ahb_take && !HWRITE && rd_addr == `OFS_CONTROL |=> HRDATA[31:6] == 26'h0)
    else $error("unimplemented control bits read nonzero");
  a_osc_pins_input: assert property (
    ctrl_r.crystal_osc_enable |-> PIN_OE == 2'h0 && PIN_READ == 2'h0 && OSC_INV_EN)
    else $error("crystal pins not forced to input");
  a_ext_arm_fall: assert property (
    ext_mode && arm_r == WAIT_FALL |-> !psc_hit)
    else $error("external count advanced before a falling edge");
  a_internal_rate: assert property (
    ctrl_r.count_enable && !ctrl_r.clock_source_select && ctrl_r.prescale_select == 2'h0
      && inc |-> ##1 !inc [*3])
    else $error("internal count faster than instruction rate");
  a_sync_delay: assert property (
    psc_hit && use_sync && !ccp_clear && !wr_low && !wr_high |=> sync_tick_r)
    else $error("synchroniser stage skipped");

  c_wrap_irq: cover property (wrap && mask_r);
  c_external_count: cover property (inc && ctrl_r.clock_source_select);
  c_prescale_eight: cover property (inc && ctrl_r.prescale_select == 2'h3);
  c_status_read: cover property (rd_hit_status && flag_r);

endmodule : timer_one

/* sim/ext_clock_source.sv */
// Model of the external count clock that drives the count pin in bursts.
`timescale 1ns/1ps
module ext_clock_source
#(
  parameter int HALF = 3
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [7:0] nrise,
  output logic pin,
  output logic busy
);
  logic [8:0] edges_r;
  logic [3:0] tmr_r;
  // The clock stands still low between bursts, so every burst starts with a rise.
  assign busy = (edges_r != 9'h000);
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      edges_r <= 9'h000;
      tmr_r <= 4'h0;
      pin <= 1'b0;
    end
    else if (go)
    begin
      edges_r <= {nrise, 1'b0};
      tmr_r <= 4'h0;
    end
    else if (busy)
    begin
      tmr_r <= (tmr_r == 4'(HALF - 1)) ? 4'h0 : tmr_r + 4'h1;
      if (tmr_r == 4'(HALF - 1))
      begin
        pin <= ~pin;
        edges_r <= edges_r - 9'h001;
      end
    end
  end
endmodule : ext_clock_source

/* sim/testbench.sv */
// Self-checking bench for the 16-bit timer, driven over AHB-Lite.
`timescale 1ns/1ps
`include "timer_one_regs.svh"
module testbench;
  logic clock = 0, sys_rst = 1, hsel = 0, hwrite = 0, go = 0, pin1 = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0, capture_compare_unit = 0, pdir = 2'b11, pout = 0, pin_oe, pin_out, pin_read;
  logic hreadyout, hresp, osc_en, irq, ext_pin, busy;
  logic [7:0] nrise = 0;
  wire [1:0] pin_wire = {pin_oe[1] ? pin_out[1] : pin1, pin_oe[0] ? pin_out[0] : ext_pin};
  int n_fail = 0, n_tests = 0;
  always #12.5 clock = ~clock;
  timer_one uut (.CLOCK(clock), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .CCP_RESET(capture_compare_unit),
    .PIN_IN(pin_wire), .PORT_DIR(pdir), .PORT_OUT(pout), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_READ(pin_read), .OSC_INV_EN(osc_en), .IRQ(irq));
  ext_clock_source src (.clock(clock), .sys_rst(sys_rst), .go(go), .nrise(nrise),
    .pin(ext_pin), .busy(busy));
  task stop_test;
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(0, a, 32'h0);
    check(name, q, exp);
    check("hresp", hresp, 0);
  endtask : rd
  task t_regs;
    rd("control", `OFS_CONTROL, 32'h0);
    rd("count low", `OFS_COUNT_LOW, 32'h0);
    rd("status", `OFS_IRQ_STATUS, 32'h0);
    rd("mask", `OFS_IRQ_MASK, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    xfer(1, `OFS_CONTROL, 32'hfe);
    rd("control", `OFS_CONTROL, 32'h3e);
    xfer(1, `OFS_CONTROL, 32'hc0);
    rd("control", `OFS_CONTROL, 32'h0);
    xfer(1, `OFS_COUNT_LOW, 32'ha5);
    xfer(1, `OFS_COUNT_HIGH, 32'h5a);
    rd("count low", `OFS_COUNT_LOW, 32'ha5);
    rd("count high", `OFS_COUNT_HIGH, 32'h5a);
  endtask : t_regs
  task t_prescale;
    logic [31:0] held;
    for (int p = 0; p < 4; p++)
    begin
      xfer(1, `OFS_COUNT_LOW, 32'h0);
      xfer(1, `OFS_COUNT_HIGH, 32'h0);
      // Sync-disable is set on purpose; the internal source must ignore it.
      xfer(1, `OFS_CONTROL, (p << 4) | 32'h5);
      repeat ((40 << p) - 2) @(posedge clock);
      xfer(1, `OFS_CONTROL, 32'h0);
      xfer(0, `OFS_COUNT_LOW, 32'h0);
      held = q;
      check("ticks", (held >= 9 && held <= 11), 1);
      repeat (20) @(posedge clock);
      rd("held", `OFS_COUNT_LOW, held);
    end
  endtask : t_prescale
  task t_overflow;
    xfer(1, `OFS_COUNT_LOW, 32'hff);
    xfer(1, `OFS_COUNT_HIGH, 32'hff);
    xfer(1, `OFS_CONTROL, 32'h1);
    repeat (12) @(posedge clock);
    check("masked irq", irq, 0);
    xfer(1, `OFS_CONTROL, 32'h0);
    xfer(1, `OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clock);
    check("irq", irq, 1);
    rd("status", `OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clock);
    check("irq cleared", irq, 0);
    rd("count high", `OFS_COUNT_HIGH, 32'h0);
  endtask : t_overflow
  task t_ccp;
    for (int i = 0; i < 2; i++)
    begin
      xfer(1, `OFS_COUNT_LOW, 32'h77);
      capture_compare_unit <= 2'(1 << i);
      @(posedge clock);
      capture_compare_unit <= 2'b00;
      rd("cleared", `OFS_COUNT_LOW, 32'h0);
    end
  endtask : t_ccp
  task t_external;
    for (int k = 0; k < 2; k++)
    begin
      xfer(1, `OFS_COUNT_LOW, 32'h0);
      xfer(1, `OFS_CONTROL, k ? 32'h17 : 32'h03);
      nrise <= 8'd9;
      go <= 1;
      @(posedge clock);
      go <= 0;
      @(posedge clock);
      for (int i = 0; i < 200 && busy; i++) @(posedge clock);
      repeat (10) @(posedge clock);
      xfer(1, `OFS_CONTROL, 32'h0);
      // The first rise comes before any fall, so only eight rises count.
      rd("rises", `OFS_COUNT_LOW, k ? 32'h4 : 32'h8);
    end
  endtask : t_external
  task t_crystal;
    pdir <= 2'b00;
    pout <= 2'b10;
    pin1 <= 1;
    xfer(1, `OFS_CONTROL, 32'h08);
    repeat (6) @(posedge clock);
    check("osc on", osc_en, 1);
    check("pin oe", pin_oe, 2'b00);
    check("pin read", pin_read, 2'b00);
    xfer(1, `OFS_CONTROL, 32'h0);
    repeat (6) @(posedge clock);
    check("osc off", osc_en, 0);
    check("pin oe", pin_oe, 2'b11);
    check("pin read", pin_read, 2'b10);
    check("pin out", pin_out, 2'b10);
  endtask : t_crystal
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    t_regs;
    t_prescale;
    t_overflow;
    t_ccp;
    t_external;
    t_crystal;
    stop_test;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test;
  end
endmodule : testbench
